// *** fpal_pkg.sv ***
// Shared constants, types and decode for the fixed-point add and logic datapath
`default_nettype none
package fpal_pkg;

  localparam int unsigned FPAL_XLEN   = 64;
  localparam int unsigned FPAL_ADDR_W = 8;
  localparam int unsigned FPAL_DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] FPAL_CTRL_OFS      = 8'h00;
  localparam logic [7:0] FPAL_INSTR_OFS     = 8'h04;
  localparam logic [7:0] FPAL_LEFT_LO_OFS   = 8'h08;
  localparam logic [7:0] FPAL_LEFT_HI_OFS   = 8'h0c;
  localparam logic [7:0] FPAL_RIGHT_LO_OFS  = 8'h10;
  localparam logic [7:0] FPAL_RIGHT_HI_OFS  = 8'h14;
  localparam logic [7:0] FPAL_STORE_LO_OFS  = 8'h18;
  localparam logic [7:0] FPAL_STORE_HI_OFS  = 8'h1c;
  localparam logic [7:0] FPAL_RESULT_LO_OFS = 8'h20;
  localparam logic [7:0] FPAL_RESULT_HI_OFS = 8'h24;
  localparam logic [7:0] FPAL_EXC_OFS       = 8'h28;
  localparam logic [7:0] FPAL_COND_OFS      = 8'h2c;
  localparam logic [7:0] FPAL_DEST_OFS      = 8'h30;
  localparam logic [7:0] FPAL_IRQ_STAT_OFS  = 8'h34;
  localparam logic [7:0] FPAL_IRQ_MASK_OFS  = 8'h38;

  // Field positions and reset values
  localparam int unsigned FPAL_CTRL_MODE64_BIT = 0;
  localparam logic        FPAL_CTRL_RST        = 1'b1;
  localparam int unsigned FPAL_DEST_BUSY_BIT   = 8;
  localparam int unsigned FPAL_IRQ_DONE_BIT    = 0;
  localparam int unsigned FPAL_IRQ_OVF_BIT     = 1;
  localparam int unsigned FPAL_IRQ_ILL_BIT     = 2;
  localparam int unsigned FPAL_IRQ_W           = 3;
  localparam logic [2:0]  FPAL_IRQ_RST         = 3'h0;

  // Instruction encodings
  localparam logic [5:0] FPAL_PRI_ADDIS = 6'h0f;
  localparam logic [5:0] FPAL_PRI_EXT   = 6'h1f;
  localparam logic [5:0] FPAL_PRI_ANDI  = 6'h1c;
  localparam logic [5:0] FPAL_PRI_ANDIS = 6'h1d;
  localparam logic [8:0] FPAL_XO_ADDME  = 9'h0ea;
  localparam logic [8:0] FPAL_XO_ADDZE  = 9'h0ca;
  localparam logic [9:0] FPAL_XO_AND    = 10'h01c;
  localparam logic [9:0] FPAL_XO_ANDC   = 10'h03c;
  localparam logic [4:0] FPAL_FLD_ZERO  = 5'h00;

  typedef enum logic [2:0] {
    FPAL_OP_NONE  = 3'h0,
    FPAL_OP_ADDIS = 3'h1,
    FPAL_OP_ADDME = 3'h2,
    FPAL_OP_ADDZE = 3'h3,
    FPAL_OP_AND   = 3'h4,
    FPAL_OP_ANDC  = 3'h5,
    FPAL_OP_ANDI  = 3'h6,
    FPAL_OP_ANDIS = 3'h7
  } fpal_op_e;

  typedef enum logic {
    FPAL_ST_IDLE = 1'b0,
    FPAL_ST_EXEC = 1'b1
  } fpal_state_e;

  typedef struct packed {
    fpal_op_e    op;
    logic [4:0]  dst;
    logic [4:0]  a_fld;
    logic        oe;
    logic        record_flag;
    logic [15:0] imm;
  } fpal_dec_s;

  typedef struct packed {
    logic [FPAL_XLEN-1:0] result;
    logic                 unsigned_wrap_bit;
    logic                 signed_wrap_bit;
    logic                 negative_bit;
    logic                 positive_bit;
    logic                 zero_result_bit;
  } fpal_alu_s;

  typedef struct packed {
    logic so;
    logic signed_wrap_bit;
    logic unsigned_wrap_bit;
  } fpal_exc_s;

  // Big-endian field numbering: bit k of the word is instr[31-k]
  function automatic fpal_dec_s fpal_decode(input logic [31:0] instr);
    fpal_dec_s d;
    d       = '0;
    d.op    = FPAL_OP_NONE;
    d.a_fld = instr[20:16];
    d.imm   = instr[15:0];
    case (instr[31:26])
      FPAL_PRI_ADDIS: begin
        d.op  = FPAL_OP_ADDIS;
        d.dst = instr[25:21];
      end
      FPAL_PRI_ANDI: begin
        d.op          = FPAL_OP_ANDI;
        d.dst         = instr[20:16];
        d.record_flag = 1'b1;
      end
      FPAL_PRI_ANDIS: begin
        d.op          = FPAL_OP_ANDIS;
        d.dst         = instr[20:16];
        d.record_flag = 1'b1;
      end
      FPAL_PRI_EXT: begin
        d.record_flag = instr[0];
        if (instr[9:1] == FPAL_XO_ADDME && instr[15:11] == FPAL_FLD_ZERO) begin
          d.op  = FPAL_OP_ADDME;
          d.dst = instr[25:21];
          d.oe  = instr[10];
        end else if (instr[9:1] == FPAL_XO_ADDZE && instr[15:11] == FPAL_FLD_ZERO) begin
          d.op  = FPAL_OP_ADDZE;
          d.dst = instr[25:21];
          d.oe  = instr[10];
        end else if (instr[10:1] == FPAL_XO_AND) begin
          d.op  = FPAL_OP_AND;
          d.dst = instr[20:16];
        end else if (instr[10:1] == FPAL_XO_ANDC) begin
          d.op  = FPAL_OP_ANDC;
          d.dst = instr[20:16];
        end else begin
          d.record_flag = 1'b0;
        end
      end
      default: begin
        d.op = FPAL_OP_NONE;
      end
    endcase
    return d;
  endfunction

  // Byte-lane merge for APB writes
  function automatic logic [31:0] fpal_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// *** fpal_alu.sv ***
// Combinational add and logic datapath with carry, overflow and compare
`default_nettype none
module fpal_alu (
  // Decoded operation
  input  wire fpal_pkg::fpal_dec_s            dec,
  input  wire logic                           mode64,
  input  wire logic                           carry_in,
  // Operands
  input  wire logic [fpal_pkg::FPAL_XLEN-1:0] left_op,
  input  wire logic [fpal_pkg::FPAL_XLEN-1:0] right_op,
  input  wire logic [fpal_pkg::FPAL_XLEN-1:0] store_op,
  // Outcome
  output var  fpal_pkg::fpal_alu_s            res
);
  import fpal_pkg::*;

  logic [FPAL_XLEN-1:0] opa;
  logic [FPAL_XLEN-1:0] opb;
  logic                 cin;
  logic                 is_add;
  logic [FPAL_XLEN-1:0] logic_r;
  logic [FPAL_XLEN:0]   sum;
  logic [32:0]          sum_lo;
  logic                 sign;
  logic                 zero;

  always_comb begin
    opa     = '0;
    opb     = '0;
    cin     = 1'b0;
    is_add  = 1'b1;
    logic_r = '0;
    case (dec.op)
      FPAL_OP_ADDIS: begin
        opa = (dec.a_fld == FPAL_FLD_ZERO) ? '0 : left_op;
        opb = {{32{dec.imm[15]}}, dec.imm, 16'h0000};
      end
      FPAL_OP_ADDME: begin
        opa = left_op;
        opb = '1;
        cin = carry_in;
      end
      FPAL_OP_ADDZE: begin
        opa = left_op;
        cin = carry_in;
      end
      FPAL_OP_AND: begin
        is_add  = 1'b0;
        logic_r = store_op & right_op;
      end
      FPAL_OP_ANDC: begin
        is_add  = 1'b0;
        logic_r = store_op & ~right_op;
      end
      FPAL_OP_ANDI: begin
        is_add  = 1'b0;
        logic_r = store_op & {48'h0, dec.imm};
      end
      FPAL_OP_ANDIS: begin
        is_add  = 1'b0;
        logic_r = store_op & {32'h0, dec.imm, 16'h0000};
      end
      default: begin
        is_add = 1'b0;
      end
    endcase
  end

  assign sum    = {1'b0, opa} + {1'b0, opb} + {{FPAL_XLEN{1'b0}}, cin};
  assign sum_lo = {1'b0, opa[31:0]} + {1'b0, opb[31:0]} + {32'h0, cin};

  // Wrapped result drives the compare, even on overflow
  always_comb begin
    res                   = '0;
    res.result            = is_add ? sum[FPAL_XLEN-1:0] : logic_r;
    res.unsigned_wrap_bit = mode64 ? sum[FPAL_XLEN] : sum_lo[32];
    res.signed_wrap_bit   = mode64 ? ((opa[63] == opb[63]) && (sum[63] != opa[63]))
                                   : ((opa[31] == opb[31]) && (sum[31] != opa[31]));
    sign                  = mode64 ? res.result[63] : res.result[31];
    zero                  = mode64 ? (res.result == '0) : (res.result[31:0] == 32'h0);
    res.negative_bit      = sign;
    res.zero_result_bit   = zero;
    res.positive_bit      = !sign && !zero;
  end

endmodule
`default_nettype wire

// *** fpal_top.sv ***
// APB-attached fixed-point add and logic unit with exception and condition state
`default_nettype none
module fpal_top (
  // Clock, reset, enable
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             ce,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [fpal_pkg::FPAL_ADDR_W-1:0] paddr,
  input  wire logic [fpal_pkg::FPAL_DATA_W-1:0] pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [fpal_pkg::FPAL_DATA_W-1:0] prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Interrupt
  output logic                                  irq
);
  import fpal_pkg::*;

  fpal_state_e          state_q;
  logic                 mode64_q;
  fpal_dec_s            dec_q;
  logic [FPAL_XLEN-1:0] left_q;
  logic [FPAL_XLEN-1:0] right_q;
  logic [FPAL_XLEN-1:0] store_q;
  logic [FPAL_XLEN-1:0] result_q;
  fpal_exc_s            exc_q;
  fpal_exc_s            exc_d;
  logic [3:0]           cond_q;
  logic [3:0]           cond_d;
  logic [4:0]           dest_q;
  logic [2:0]           irq_stat_q;
  logic [2:0]           irq_mask_q;
  logic [2:0]           irq_evt;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  fpal_alu_s            alu;

  logic        setup;
  logic        acc;
  logic        wr;
  logic        exec;
  logic        is_carry_op;
  logic        is_legal;
  logic        mapped;
  logic [31:0] rd_word;

  fpal_alu u_alu (
    .dec      (dec_q),
    .mode64   (mode64_q),
    .carry_in (exc_q.unsigned_wrap_bit),
    .left_op  (left_q),
    .right_op (right_q),
    .store_op (store_q),
    .res      (alu)
  );

  // Zero-wait access; a frozen block holds the bus off
  assign pready  = ce;
  assign setup   = ce && psel && !penable;
  assign acc     = ce && psel && penable;
  assign wr      = acc && pwrite;
  assign exec    = ce && (state_q == FPAL_ST_EXEC);
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign irq     = |(irq_stat_q & irq_mask_q);

  assign is_carry_op = (dec_q.op == FPAL_OP_ADDME) || (dec_q.op == FPAL_OP_ADDZE);
  assign is_legal    = (dec_q.op != FPAL_OP_NONE);

  always_comb begin
    case (paddr)
      FPAL_CTRL_OFS, FPAL_INSTR_OFS,
      FPAL_LEFT_LO_OFS, FPAL_LEFT_HI_OFS,
      FPAL_RIGHT_LO_OFS, FPAL_RIGHT_HI_OFS,
      FPAL_STORE_LO_OFS, FPAL_STORE_HI_OFS,
      FPAL_RESULT_LO_OFS, FPAL_RESULT_HI_OFS,
      FPAL_EXC_OFS, FPAL_COND_OFS, FPAL_DEST_OFS,
      FPAL_IRQ_STAT_OFS, FPAL_IRQ_MASK_OFS: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Sequencer: an instruction write starts one execute cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FPAL_ST_IDLE;
    end else if (ce) begin
      case (state_q)
        FPAL_ST_IDLE: begin
          if (wr && paddr == FPAL_INSTR_OFS) begin
            state_q <= FPAL_ST_EXEC;
          end
        end
        FPAL_ST_EXEC: begin
          state_q <= FPAL_ST_IDLE;
        end
        default: begin
          state_q <= FPAL_ST_IDLE;
        end
      endcase
    end
  end

  // Instruction capture and decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= '0;
    end else if (wr && paddr == FPAL_INSTR_OFS && state_q == FPAL_ST_IDLE) begin
      dec_q <= fpal_decode(fpal_merge(32'h0, pwdata, pstrb));
    end
  end

  // Mode control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode64_q <= FPAL_CTRL_RST;
    end else if (wr && paddr == FPAL_CTRL_OFS && pstrb[0]) begin
      mode64_q <= pwdata[FPAL_CTRL_MODE64_BIT];
    end
  end

  // Operand registers, written in 32-bit halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q  <= '0;
      right_q <= '0;
      store_q <= '0;
    end else if (wr) begin
      case (paddr)
        FPAL_LEFT_LO_OFS:  left_q[31:0]   <= fpal_merge(left_q[31:0], pwdata, pstrb);
        FPAL_LEFT_HI_OFS:  left_q[63:32]  <= fpal_merge(left_q[63:32], pwdata, pstrb);
        FPAL_RIGHT_LO_OFS: right_q[31:0]  <= fpal_merge(right_q[31:0], pwdata, pstrb);
        FPAL_RIGHT_HI_OFS: right_q[63:32] <= fpal_merge(right_q[63:32], pwdata, pstrb);
        FPAL_STORE_LO_OFS: store_q[31:0]  <= fpal_merge(store_q[31:0], pwdata, pstrb);
        FPAL_STORE_HI_OFS: store_q[63:32] <= fpal_merge(store_q[63:32], pwdata, pstrb);
        default: begin
        end
      endcase
    end
  end

  // Result and destination index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
      dest_q   <= '0;
    end else if (exec && is_legal) begin
      result_q <= alu.result;
      dest_q   <= dec_q.dst;
    end
  end

  // Exception register next value
  always_comb begin
    exc_d = exc_q;
    if (exec && is_carry_op) begin
      exc_d.unsigned_wrap_bit = alu.unsigned_wrap_bit;
      if (dec_q.oe) begin
        exc_d.signed_wrap_bit = alu.signed_wrap_bit;
        exc_d.so              = exc_q.so | alu.signed_wrap_bit;
      end
    end
  end

  // Execution has priority over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= '0;
    end else if (exec) begin
      exc_q <= exc_d;
    end else if (wr && paddr == FPAL_EXC_OFS && pstrb[0]) begin
      exc_q <= pwdata[2:0];
    end
  end

  // Condition field: negative, positive, zero, sticky copy
  assign cond_d = {alu.negative_bit, alu.positive_bit, alu.zero_result_bit, exc_d.so};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_q <= '0;
    end else if (exec && is_legal && dec_q.record_flag) begin
      cond_q <= cond_d;
    end
  end

  // Interrupt events and sticky status; a new event beats a clear
  always_comb begin
    irq_evt                    = '0;
    irq_evt[FPAL_IRQ_DONE_BIT] = exec && is_legal;
    irq_evt[FPAL_IRQ_OVF_BIT]  = exec && is_carry_op && dec_q.oe && alu.signed_wrap_bit;
    irq_evt[FPAL_IRQ_ILL_BIT]  = exec && !is_legal;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= FPAL_IRQ_RST;
    end else if (ce) begin
      if (wr && paddr == FPAL_IRQ_STAT_OFS && pstrb[0]) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[FPAL_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= FPAL_IRQ_RST;
    end else if (wr && paddr == FPAL_IRQ_MASK_OFS && pstrb[0]) begin
      irq_mask_q <= pwdata[FPAL_IRQ_W-1:0];
    end
  end

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_word = 32'h0;
    case (paddr)
      FPAL_CTRL_OFS:      rd_word[FPAL_CTRL_MODE64_BIT] = mode64_q;
      FPAL_LEFT_LO_OFS:   rd_word = left_q[31:0];
      FPAL_LEFT_HI_OFS:   rd_word = left_q[63:32];
      FPAL_RIGHT_LO_OFS:  rd_word = right_q[31:0];
      FPAL_RIGHT_HI_OFS:  rd_word = right_q[63:32];
      FPAL_STORE_LO_OFS:  rd_word = store_q[31:0];
      FPAL_STORE_HI_OFS:  rd_word = store_q[63:32];
      FPAL_RESULT_LO_OFS: rd_word = result_q[31:0];
      FPAL_RESULT_HI_OFS: rd_word = result_q[63:32];
      FPAL_EXC_OFS:       rd_word[2:0] = exc_q;
      FPAL_COND_OFS:      rd_word[3:0] = cond_q;
      FPAL_DEST_OFS: begin
        rd_word[4:0]               = dest_q;
        rd_word[FPAL_DEST_BUSY_BIT] = (state_q == FPAL_ST_EXEC);
      end
      FPAL_IRQ_STAT_OFS:  rd_word[FPAL_IRQ_W-1:0] = irq_stat_q;
      FPAL_IRQ_MASK_OFS:  rd_word[FPAL_IRQ_W-1:0] = irq_mask_q;
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  // Read data is sampled in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0 : rd_word;
      pslverr_q <= !mapped;
    end
  end

endmodule
`default_nettype wire

// *** fpal_top_props.sv ***
// Port-level checks for the add and logic unit
`default_nettype none
module fpal_top_props (
  // Clock, reset, enable
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             ce,
  // APB
  input wire logic                             psel,
  input wire logic                             penable,
  input wire logic                             pwrite,
  input wire logic [fpal_pkg::FPAL_ADDR_W-1:0] paddr,
  input wire logic [fpal_pkg::FPAL_DATA_W-1:0] pwdata,
  input wire logic [3:0]                       pstrb,
  input wire logic [fpal_pkg::FPAL_DATA_W-1:0] prdata,
  input wire logic                             pready,
  input wire logic                             pslverr,
  // Interrupt
  input wire logic                             irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  logic acc;
  logic rd_acc;
  logic instr_w;
  logic mask_w;
  assign acc     = psel && penable && ce;
  assign rd_acc  = acc && !pwrite;
  assign instr_w = acc && pwrite && (paddr == FPAL_INSTR_OFS);
  assign mask_w  = acc && pwrite && (paddr == FPAL_IRQ_MASK_OFS);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_mask_off;
    mask_w && pstrb[0] && (pwdata[2:0] == 3'h0);
  endsequence
  // Edge before was frozen, so irq and prdata may not have moved since
  sequence s_frozen;
    !ce ##1 1'b1;
  endsequence
  property p_ready_ce; pready == ce; endproperty
  property p_unmapped; acc && paddr > FPAL_IRQ_MASK_OFS |-> pslverr && prdata == '0; endproperty
  property p_mapped; acc && paddr <= FPAL_IRQ_MASK_OFS && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_wr_zero; acc && pwrite |-> prdata == '0; endproperty
  property p_instr_rd; rd_acc && paddr == FPAL_INSTR_OFS |-> prdata == '0; endproperty
  property p_exc_rd; rd_acc && paddr == FPAL_EXC_OFS |-> prdata[31:3] == '0; endproperty
  property p_cond_rd; rd_acc && paddr == FPAL_COND_OFS |-> prdata[31:4] == '0; endproperty
  property p_mask_off; s_mask_off |=> !irq; endproperty
  // Only a mask write or a finished instruction can raise the line
  property p_irq_cause; $rose(irq) |-> $past(mask_w) || $past(instr_w, 2); endproperty
  property p_frozen; s_frozen |-> $stable(irq) && $stable(prdata); endproperty
  a_ready_ce: assert property (p_ready_ce) else $error("pready differs from ce");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  a_instr_rd: assert property (p_instr_rd) else $error("instruction word readable");
  a_exc_rd: assert property (p_exc_rd) else $error("exception word spare bits set");
  a_cond_rd: assert property (p_cond_rd) else $error("condition word spare bits set");
  a_mask_off: assert property (p_mask_off) else $error("irq high with mask cleared");
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  a_frozen: assert property (p_frozen) else $error("state moved while ce low");
endmodule
`default_nettype wire

// *** fpal_regfile_model.sv ***
// Register-file and decode side model: loads operands and instructions over APB
`default_nettype none
module fpal_regfile_model (
  // Clock and answer
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  int stuck = 0;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end
  // Held until pready is seen; a bounded wait so a frozen slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    if (n >= 100) stuck++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Instruction goes last because writing it starts the run
  task automatic load(input logic [63:0] l, r, s, input logic [31:0] ins);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, FPAL_LEFT_LO_OFS, l[31:0], q, e);
    xfer(1'b1, FPAL_LEFT_HI_OFS, l[63:32], q, e);
    xfer(1'b1, FPAL_RIGHT_LO_OFS, r[31:0], q, e);
    xfer(1'b1, FPAL_RIGHT_HI_OFS, r[63:32], q, e);
    xfer(1'b1, FPAL_STORE_LO_OFS, s[31:0], q, e);
    xfer(1'b1, FPAL_STORE_HI_OFS, s[63:32], q, e);
    xfer(1'b1, FPAL_INSTR_OFS, ins, q, e);
  endtask
endmodule
`default_nettype wire

// *** fpal_top_tb.sv ***
// Self-checking bench for the add and logic unit
`default_nettype none
module fpal_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  localparam logic [7:0] RST_A [8] = '{8'h00, 8'h28, 8'h2c, 8'h34, 8'h38, 8'h04, 8'h20, 8'h30};
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  int          n_fail = 0;
  int          check_count = 0;
  fpal_top dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq)
  );
  fpal_regfile_model model_u (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic guard();
    if (model_u.stuck != 0) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    model_u.xfer(1'b1, a, d, q, e);
    guard();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    model_u.xfer(1'b0, a, 32'h0, q, e);
    guard();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    rd(a, q, e);
    check({31'h0, e, q}, {32'h0, exp});
  endtask
  // Runs one instruction and compares result, exception, condition and destination
  task automatic op(input logic [31:0] ins, input logic [63:0] l, r, s, exp,
                    input logic [2:0] x, input logic [3:0] c, input logic [4:0] dst);
    logic [31:0] lo;
    logic [31:0] hi;
    logic        e;
    model_u.load(l, r, s, ins);
    guard();
    rd(FPAL_RESULT_LO_OFS, lo, e);
    rd(FPAL_RESULT_HI_OFS, hi, e);
    check({hi, lo}, exp);
    rd_chk(FPAL_EXC_OFS, {29'h0, x});
    rd_chk(FPAL_COND_OFS, {28'h0, c});
    rd_chk(FPAL_DEST_OFS, {27'h0, dst});
  endtask
  function automatic logic [31:0] ins_x(input logic [4:0] d, a, b, input logic [10:0] lo);
    return {6'h1f, d, a, b, lo};
  endfunction
  initial begin
    logic [31:0] q;
    logic        e;
    presetn = 1'b0;
    ce      = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Read-only places must ignore writes
    wr(FPAL_RESULT_LO_OFS, 32'hffff_ffff);
    wr(FPAL_DEST_OFS, 32'h0000_001f);
    for (int i = 0; i < 8; i++) begin
      rd_chk(RST_A[i], (i == 0) ? 32'h1 : 32'h0);
    end
    rd(8'h40, q, e);
    check({q, 31'h0, e}, 64'h1);
    wr(FPAL_EXC_OFS, 32'h1);
    op({6'h0f, 5'h05, 5'h00, 16'h8000}, 64'h1234, 64'h0, 64'h0, 64'hffff_ffff_8000_0000,
       3'h1, 4'h0, 5'h05);
    op({6'h0f, 5'h06, 5'h03, 16'h0001}, 64'hffff_0000, 64'h0, 64'h0, 64'h1_0000_0000,
       3'h1, 4'h0, 5'h06);
    wr(FPAL_EXC_OFS, 32'h0);
    wr(FPAL_IRQ_MASK_OFS, 32'h2);
    op(ins_x(5'h08, 5'h02, 5'h00, {1'b1, 9'h0ea, 1'b1}), 64'h8000_0000_0000_0000, 64'h0, 64'h0,
       64'h7fff_ffff_ffff_ffff, 3'h7, 4'h5, 5'h08);
    check({63'h0, irq}, 64'h1);
    rd_chk(FPAL_IRQ_STAT_OFS, 32'h3);
    wr(FPAL_IRQ_STAT_OFS, 32'h7);
    check({63'h0, irq}, 64'h0);
    op(ins_x(5'h09, 5'h02, 5'h00, {1'b0, 9'h0ca, 1'b1}), 64'h0, 64'h0, 64'h0,
       64'h1, 3'h6, 4'h5, 5'h09);
    wr(FPAL_EXC_OFS, 32'h1);
    op(ins_x(5'h0a, 5'h02, 5'h00, {1'b1, 9'h0ca, 1'b0}), 64'h7fff_ffff_ffff_ffff, 64'h0, 64'h0,
       64'h8000_0000_0000_0000, 3'h6, 4'h5, 5'h0a);
    wr(FPAL_CTRL_OFS, 32'h0);
    wr(FPAL_EXC_OFS, 32'h1);
    op(ins_x(5'h0b, 5'h02, 5'h00, {1'b1, 9'h0ca, 1'b1}), 64'h7fff_ffff, 64'h0, 64'h0,
       64'h8000_0000, 3'h6, 4'h9, 5'h0b);
    op(ins_x(5'h0c, 5'h02, 5'h00, {1'b0, 9'h0ea, 1'b1}), 64'h1_0000_0000, 64'h0, 64'h0,
       64'hffff_ffff, 3'h6, 4'h9, 5'h0c);
    wr(FPAL_CTRL_OFS, 32'h1);
    op(ins_x(5'h01, 5'h0a, 5'h02, {10'h01c, 1'b0}), 64'h0, 64'h0ff0_ffff_0000_ffff,
       64'hf0f0_1234_5678_9abc, 64'h00f0_1234_0000_9abc, 3'h6, 4'h9, 5'h0a);
    op({6'h1c, 5'h01, 5'h0b, 16'hc543}, 64'h0, 64'h0, 64'hf0f0_1234_5678_9abc,
       64'h8000, 3'h6, 4'h5, 5'h0b);
    op(ins_x(5'h01, 5'h0c, 5'h02, {10'h03c, 1'b1}), 64'h0, 64'hffff_ffff_ffff_ffff,
       64'hf0f0_1234_5678_9abc, 64'h0, 3'h6, 4'h3, 5'h0c);
    op({6'h1d, 5'h01, 5'h0d, 16'hf000}, 64'h0, 64'h0, 64'hf0f0_1234_5678_9abc,
       64'h5000_0000, 3'h6, 4'h5, 5'h0d);
    // Nonzero field where zero is required is refused; result, exception, condition and destination hold, the illegal bit sets
    wr(FPAL_IRQ_MASK_OFS, 32'h4);
    op(ins_x(5'h01, 5'h02, 5'h01, {1'b0, 9'h0ea, 1'b1}), 64'h1, 64'h0, 64'h0,
       64'h5000_0000, 3'h6, 4'h5, 5'h0d);
    check({63'h0, irq}, 64'h1);
    wr(FPAL_IRQ_MASK_OFS, 32'h0);
    check({63'h0, irq}, 64'h0);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    check({63'h0, pready}, 64'h0);
    ce <= 1'b1;
    @(posedge pclk);
    report_and_stop();
  end
endmodule
bind fpal_top fpal_top_props props_u (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq)
);
`default_nettype wire
